// file: fast_serial_port_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the fast serial port
// Assumes: APB with 32-bit data, every register one aligned word
// Notes:   register data sits in the low bits, the bits above read as zero
//
// Function
// - bytes go out and come in least significant bit first, high means one
// - block mode transmit stop interval lasts gap value minus nine bit times, one bit time for a gap value of nine or less
// - gap value resets to give a two bit time stop interval
// - receive line is asynchronous and is synchronised before sampling
// - receiver tolerates five percent rate error with divisor of 23 or more
// - byte mode received bytes are pushed into a receive fifo
// - receive-ready flag is high exactly while the receive fifo is not empty
// - block mode received bytes are written straight to the memory port
// - with handshake on, start bit waits while clear-to-send is low
// - request-to-send drops during the third data bit of a handshaked byte
`ifndef FAST_SERIAL_PORT_CONSTS_SVH
`define FAST_SERIAL_PORT_CONSTS_SVH

// register byte addresses
`define FSP_CTRL_ADDR      16'hc070
`define FSP_GAP_ADDR       16'hc074
`define FSP_BAUD_ADDR      16'hc078
`define FSP_TXDATA_ADDR    16'hc07c
`define FSP_RXDATA_ADDR    16'hc080
`define FSP_STATUS_ADDR    16'hc084
`define FSP_IRQ_STAT_ADDR  16'hc088
`define FSP_IRQ_MASK_ADDR  16'hc08c
`define FSP_RXBASE_ADDR    16'hc090

// control fields
`define FSP_CTRL_BLOCK     0
`define FSP_CTRL_HSHAKE    1

// status fields
`define FSP_STAT_RX_BYTE_AVAILABLE     0
`define FSP_STAT_TXBUSY    1
`define FSP_STAT_TXPEND    2

// interrupt fields
`define FSP_IRQ_RXBYTE     0
`define FSP_IRQ_TXDONE     1
`define FSP_IRQ_OVERRUN    2
`define FSP_IRQ_FRAMING    3
`define FSP_IRQ_WIDTH      4

// reset values and timing
`define FSP_GAP_OFFSET     16'h0009
`define FSP_GAP_RESET      16'h000b
`define FSP_BAUD_RESET     16'h0017

`endif

// file: fast_serial_port_pkg.sv
// Purpose: types shared by the fast serial port
// Assumes: nothing beyond the constants header
// Notes:   state codes are one-hot
`default_nettype none
package fast_serial_port_pkg;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_CTS   = 5'h02,
    TX_START = 5'h04,
    TX_DATA  = 5'h08,
    TX_STOP  = 5'h10
  } tx_state_type;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_type;

endpackage
`default_nettype wire

// file: fast_serial_port.sv
// Purpose: fast serial port with byte and block modes, apb register access
// Assumes: pclk 10 MHz; apb inputs synchronous; serial_rx_line asynchronous
// Notes:   bit time is baud_divisor pclk cycles; one transmit holding register
//
// Local design decision: the APB register port.
`include "fast_serial_port_consts.svh"
`default_nettype none
module fast_serial_port
  import fast_serial_port_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW    = 4,
  parameter int MEM_AW     = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              serial_rx_line,
  output logic                   serial_tx_line,
  input  wire logic              clear_to_send_in,
  output logic                   request_to_send_out,
  output logic                   mem_wr_valid,
  output logic      [MEM_AW-1:0] mem_wr_addr,
  output logic      [7:0]        mem_wr_data,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0]               ctrl_q;
  logic [15:0]              gap_q;
  logic [15:0]              baud_q;
  logic [7:0]               tx_hold_q;
  logic                     tx_pend_q;
  logic [`FSP_IRQ_WIDTH-1:0] istat_q;
  logic [`FSP_IRQ_WIDTH-1:0] imask_q;
  logic [31:0]              prdata_q;
  logic                     pready_q;
  logic                     pslverr_q;
  logic                     irq_q;

  // transmit
  tx_state_type             tx_state_q;
  logic [15:0]              tx_cnt_q;
  logic [15:0]              tx_bits_q;
  logic [7:0]               tx_shift_q;
  logic                     txd_q;
  logic                     rts_q;

  // receive
  rx_state_type             rx_state_q;
  logic                     rx_s1_q;
  logic                     rx_s2_q;
  logic                     rx_prev_q;
  logic [15:0]              rx_cnt_q;
  logic [2:0]               rx_idx_q;
  logic [7:0]               rx_shift_q;

  // fifo and memory port
  logic [7:0]               fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0]       wr_ptr_q;
  logic [FIFO_AW-1:0]       rd_ptr_q;
  logic [FIFO_AW:0]         count_q;
  logic                     mem_valid_q;
  logic [MEM_AW-1:0]        mem_addr_q;
  logic [7:0]               mem_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic setup_ph   = psel & ~penable;
  wire logic access_ph  = psel & penable & pready_q;
  wire logic wr_acc     = access_ph & pwrite;
  wire logic rd_acc     = access_ph & ~pwrite;
  wire logic hit_ctrl   = (paddr == `FSP_CTRL_ADDR);
  wire logic hit_gap    = (paddr == `FSP_GAP_ADDR);
  wire logic hit_baud   = (paddr == `FSP_BAUD_ADDR);
  wire logic hit_txdata = (paddr == `FSP_TXDATA_ADDR);
  wire logic hit_rxdata = (paddr == `FSP_RXDATA_ADDR);
  wire logic hit_status = (paddr == `FSP_STATUS_ADDR);
  wire logic hit_istat  = (paddr == `FSP_IRQ_STAT_ADDR);
  wire logic hit_imask  = (paddr == `FSP_IRQ_MASK_ADDR);
  wire logic hit_rxbase = (paddr == `FSP_RXBASE_ADDR);
  wire logic mapped     = hit_ctrl | hit_gap | hit_baud | hit_txdata | hit_rxdata
                        | hit_status | hit_istat | hit_imask | hit_rxbase;

  wire logic block_mode = ctrl_q[`FSP_CTRL_BLOCK];
  wire logic hshake_en  = ctrl_q[`FSP_CTRL_HSHAKE];
  wire logic fifo_empty = (count_q == '0);
  wire logic fifo_full  = (count_q == (FIFO_AW+1)'(FIFO_DEPTH));
  wire logic rx_ready   = ~fifo_empty;
  wire logic tx_busy    = ~tx_state_q[0];
  wire logic [15:0] div = (baud_q == '0) ? 16'h0001 : baud_q;

  // read mux, captured in the setup cycle
  wire logic [31:0] rd_mux =
      hit_ctrl   ? {30'h0, ctrl_q} :
      hit_gap    ? {16'h0, gap_q} :
      hit_baud   ? {16'h0, baud_q} :
      hit_rxdata ? {24'h0, fifo_mem[rd_ptr_q]} :
      hit_status ? {29'h0, tx_pend_q, tx_busy, rx_ready} :
      hit_istat  ? {28'h0, istat_q} :
      hit_imask  ? {28'h0, imask_q} :
      hit_rxbase ? {{(32-MEM_AW){1'b0}}, mem_addr_q} : 32'h0;

  // zero-wait answer: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      if (setup_ph) prdata_q <= (pwrite | fifo_empty & hit_rxdata) ? 32'h0 : rd_mux;
    end
  end

  // software registers; gap resets to two bit times of stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 2'h0;
      gap_q   <= `FSP_GAP_RESET;
      baud_q  <= `FSP_BAUD_RESET;
      imask_q <= '0;
    end else if (wr_acc) begin
      if (hit_ctrl)  ctrl_q  <= pwdata[1:0];
      if (hit_gap)   gap_q   <= pwdata[15:0];
      if (hit_baud)  baud_q  <= pwdata[15:0];
      if (hit_imask) imask_q <= pwdata[`FSP_IRQ_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit side
  wire logic tx_write   = wr_acc & hit_txdata;
  wire logic tx_tick    = (tx_cnt_q == div - 16'h0001);
  wire logic tx_done    = tx_state_q[4] & tx_tick & (tx_bits_q == 16'h0000);
  // a pending byte leaves straight from the last stop tick: no idle cycle stretches the gap
  wire logic tx_launch  = (tx_state_q[0] | tx_done) & tx_pend_q;
  wire logic tx_overrun = tx_write & tx_pend_q & ~tx_launch;
  // block mode stop lasts gap-9 bit times, never below one
  wire logic [15:0] stop_bits = (block_mode && gap_q > `FSP_GAP_OFFSET)
                              ? gap_q - `FSP_GAP_OFFSET : 16'h0001;

  // holding register; a write while full is dropped and flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend_q <= 1'b0;
      tx_hold_q <= 8'h00;
    end else if (tx_write && (!tx_pend_q || tx_launch)) begin
      tx_pend_q <= 1'b1;
      tx_hold_q <= pwdata[7:0];
    end else if (tx_launch) begin
      tx_pend_q <= 1'b0;
    end
  end

  // frame sequencer: start, eight data lsb first, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= 16'h0;
      tx_bits_q  <= 16'h0;
      tx_shift_q <= 8'h00;
      txd_q      <= 1'b1;
      rts_q      <= 1'b0;
    end else begin
      tx_cnt_q <= (tx_tick || tx_state_q[0] || tx_state_q[1]) ? 16'h0 : tx_cnt_q + 16'h0001;
      case (tx_state_q)
        TX_IDLE: begin
          txd_q <= 1'b1;
        end
        TX_CTS: begin
          if (clear_to_send_in) begin
            txd_q      <= 1'b0;
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          txd_q <= 1'b0;
          if (tx_tick) begin
            txd_q      <= tx_shift_q[0];
            tx_bits_q  <= 16'h0007;
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            if (tx_bits_q == 16'h0006) rts_q <= 1'b0;
            if (tx_bits_q == 16'h0000) begin
              txd_q      <= 1'b1;
              tx_bits_q  <= stop_bits - 16'h0001;
              tx_state_q <= TX_STOP;
            end else begin
              txd_q     <= tx_shift_q[1];
              tx_bits_q <= tx_bits_q - 16'h0001;
            end
          end
        end
        TX_STOP: begin
          txd_q <= 1'b1;
          if (tx_tick) begin
            if (tx_bits_q == 16'h0000) tx_state_q <= TX_IDLE;
            else tx_bits_q <= tx_bits_q - 16'h0001;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
      // launch: without handshake the start bit goes low at once, so it lasts a full bit
      if (tx_launch) begin
        tx_shift_q <= tx_hold_q;
        rts_q      <= hshake_en;
        txd_q      <= hshake_en;
        tx_state_q <= hshake_en ? TX_CTS : TX_START;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive side
  // two-flop synchroniser; only rx_s2_q is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= serial_rx_line;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  wire logic rx_fall = rx_prev_q & ~rx_s2_q;
  wire logic rx_half = (rx_cnt_q == (div >> 1));
  wire logic rx_tick = (rx_cnt_q == div - 16'h0001);
  wire logic rx_stop = rx_state_q[3] & rx_tick;
  wire logic rx_good = rx_stop & rx_s2_q;
  wire logic rx_ferr = rx_stop & ~rx_s2_q;
  wire logic pop     = rd_acc & hit_rxdata & ~fifo_empty;
  wire logic push    = rx_good & ~block_mode & (~fifo_full | pop);
  wire logic rx_ovr  = rx_good & ~block_mode & fifo_full & ~pop;

  // centre sampling: realign at start bit middle keeps drift to the nine bit times up to the stop sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 16'h0;
      rx_idx_q   <= 3'h0;
      rx_shift_q <= 8'h00;
    end else begin
      rx_cnt_q <= rx_cnt_q + 16'h0001;
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= 16'h0;
          if (rx_fall) rx_state_q <= RX_START;
        end
        RX_START: begin
          if (rx_half) begin
            rx_cnt_q   <= 16'h0;
            rx_idx_q   <= 3'h0;
            rx_state_q <= rx_s2_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_cnt_q   <= 16'h0;
            rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]};
            rx_idx_q   <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // byte mode fifo; occupancy drives the ready flag
  always_ff @(posedge pclk) begin
    if (push) fifo_mem[wr_ptr_q] <= rx_shift_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == FIFO_AW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= (rd_ptr_q == FIFO_AW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
    end
  end

  // block mode: bytes bypass the fifo to the memory write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid_q <= 1'b0;
      mem_addr_q  <= '0;
      mem_data_q  <= 8'h00;
    end else begin
      mem_valid_q <= rx_good & block_mode;
      if (rx_good && block_mode) mem_data_q <= rx_shift_q;
      if (wr_acc && hit_rxbase) mem_addr_q <= pwdata[MEM_AW-1:0];
      else if (mem_valid_q) mem_addr_q <= mem_addr_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, a new event wins over the clear
  wire logic [`FSP_IRQ_WIDTH-1:0] events = {rx_ferr, rx_ovr | tx_overrun, tx_done, rx_good};
  wire logic [`FSP_IRQ_WIDTH-1:0] wclr   = (wr_acc & hit_istat)
                                          ? pwdata[`FSP_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~wclr) | events;
      irq_q   <= |(((istat_q & ~wclr) | events) & imask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign serial_tx_line      = txd_q;
  assign request_to_send_out = rts_q;
  assign mem_wr_valid        = mem_valid_q;
  assign mem_wr_addr         = mem_addr_q;
  assign mem_wr_data         = mem_data_q;
  assign irq                 = irq_q;

endmodule // fast_serial_port
`default_nettype wire

// file: fast_serial_port_checker.sv
// Purpose: port-level checks of the fast serial port
// Assumes: baud divisor at 23 whenever handshake is on
// Notes:   started_q marks a handshaked start bit already out
`include "fast_serial_port_consts.svh"
`default_nettype none
module fast_serial_port_checker #(
  parameter int MEM_AW = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [15:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              serial_rx_line,
  input wire logic              serial_tx_line,
  input wire logic              clear_to_send_in,
  input wire logic              request_to_send_out,
  input wire logic              mem_wr_valid,
  input wire logic [MEM_AW-1:0] mem_wr_addr,
  input wire logic [7:0]        mem_wr_data,
  input wire logic              irq
);
  localparam int RTS_LO = 68;
  localparam int RTS_HI = 70;
  logic mapped;
  logic started_q;
  // mapped window is word aligned c070 to c090
  assign mapped = paddr >= `FSP_CTRL_ADDR && paddr <= `FSP_RXBASE_ADDR && paddr[1:0] == 2'h0;
  // once the start bit is out cts may fall, so stop the holdoff check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) started_q <= 1'b0;
    else if (!request_to_send_out) started_q <= 1'b0;
    else if (!serial_tx_line) started_q <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_cts_holdoff: assert property (request_to_send_out && !started_q && !clear_to_send_in && serial_tx_line |=> serial_tx_line)
    else $error("start bit sent while cts low");
  a_rts_third_bit: assert property ($fell(serial_tx_line) && request_to_send_out && !started_q |-> ##[RTS_LO:RTS_HI] $fell(request_to_send_out))
    else $error("rts not dropped in third data bit");
  a_mem_one_pulse: assert property (mem_wr_valid |=> !mem_wr_valid)
    else $error("memory write pulse too long");
  a_mem_addr_step: assert property (mem_wr_valid |=> mem_wr_addr == $past(mem_wr_addr) + 1'b1)
    else $error("memory address not stepped");
  a_start_bit_low: assert property ($fell(serial_tx_line) && !started_q |-> (!serial_tx_line)[*8])
    else $error("start bit too short");
  c_mem_write: cover property (mem_wr_valid);
  c_rts_drop: cover property ($fell(request_to_send_out));
  c_slverr: cover property (pslverr);
endmodule // fast_serial_port_checker

bind fast_serial_port fast_serial_port_checker #(.MEM_AW(MEM_AW)) checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .serial_rx_line, .serial_tx_line, .clear_to_send_in, .request_to_send_out,
  .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .irq
);
`default_nettype wire

// file: serial_far_end.sv
// Purpose: far end serial device with hardware flow control
// Assumes: bit time handed over per call in pclk cycles
// Notes:   line idles high between frames, as with a pull-up
`default_nettype none
module serial_far_end (
  input  wire logic pclk,
  input  wire logic tx_line,
  input  wire logic rts_in,
  output logic      rx_line,
  output logic      cts_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold_off = 1'b0;
  initial begin
    rx_line = 1'b1;
    cts_out = 1'b1;
  end
  // cts follows !hold_off one cycle late; rts_in is not looked at
  always @(posedge pclk) cts_out <= !hold_off;
  ////////////////////////////////////////////////////////////
  // low start, data lsb first with high as one, high stop
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (bt) @(posedge pclk);
    end
  endtask
  // samples each bit at its centre, rts watched only by the checker and the bench
  task automatic recv(output logic [7:0] b, input int bt);
    while (tx_line !== 1'b0) @(posedge pclk);
    repeat (bt / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge pclk);
      b[i] = tx_line;
    end
  endtask
endmodule // serial_far_end
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench of the fast serial port
// Assumes: pclk 10 MHz, baud divisor left at 23
// Notes:   random bytes from a fixed xorshift seed
`include "fast_serial_port_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_rx_line;
  logic        serial_tx_line;
  logic        clear_to_send_in;
  logic        request_to_send_out;
  logic        mem_wr_valid;
  logic [15:0] mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic        irq;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  int          bts[3] = '{23, 22, 24};
  logic [15:0] gaps[3] = '{16'h000b, 16'h000d, 16'h0005};
  logic [31:0] seed = 32'h00000007;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  b;
  logic [7:0]  got;
  logic [15:0] base;
  initial forever #50 pclk = ~pclk;
  fast_serial_port fast_serial_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_rx_line, .serial_tx_line, .clear_to_send_in,
    .request_to_send_out, .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .irq);
  serial_far_end serial_far_end_i (.pclk, .tx_line(serial_tx_line),
    .rts_in(request_to_send_out), .rx_line(serial_rx_line), .cts_out(clear_to_send_in));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // whole block frame in bits: start, eight data, stop of at least one
  function automatic int frame_bits(input logic [15:0] g);
    return 9 + ((g > 16'h0009) ? int'(g) - 9 : 1);
  endfunction
  // one apb transfer, entered just after an edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input int k, input logic v);
    apb(1'b0, `FSP_STATUS_ADDR, 32'h0);
    while (rd[k] !== v) apb(1'b0, `FSP_STATUS_ADDR, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FSP_GAP_ADDR, 32'h0);
    `CHK("gap reset", 32'h0000000b, rd)
    apb(1'b0, 16'hc0fc, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    $display("test registers done");
    // byte mode receive at nominal and skewed rates, irq masked after the first
    foreach (bts[i]) begin
      rd = rnd();
      b = rd[7:0];
      apb(1'b1, `FSP_IRQ_MASK_ADDR, {31'h0, i == 0});
      serial_far_end_i.send(b, bts[i]);
      poll(`FSP_STAT_RX_BYTE_AVAILABLE, 1'b1);
      `CHK("irq", i == 0, irq)
      apb(1'b0, `FSP_RXDATA_ADDR, 32'h0);
      `CHK("rx byte", b, rd[7:0])
      apb(1'b0, `FSP_STATUS_ADDR, 32'h0);
      `CHK("rx ready", 1'b0, rd[0])
      apb(1'b1, `FSP_IRQ_STAT_ADDR, 32'h0000000f);
      @(posedge pclk);
      `CHK("irq clear", 1'b0, irq)
    end
    $display("test byte receive done");
    rd = rnd();
    b = rd[7:0];
    fork
      apb(1'b1, `FSP_TXDATA_ADDR, {24'h0, b});
      serial_far_end_i.recv(got, 23);
    join
    `CHK("tx byte", b, got)
    poll(`FSP_STAT_TXBUSY, 1'b0);
    $display("test byte transmit done");
    // handshake: cts low well before launch, start must wait
    apb(1'b1, `FSP_CTRL_ADDR, 32'h2);
    serial_far_end_i.hold_off <= 1'b1;
    @(posedge pclk);
    rd = rnd();
    b = rd[7:0];
    apb(1'b1, `FSP_TXDATA_ADDR, {24'h0, b});
    repeat (40) @(posedge pclk);
    `CHK("tx held", 1'b1, serial_tx_line)
    `CHK("rts up", 1'b1, request_to_send_out)
    fork
      serial_far_end_i.hold_off <= 1'b0;
      serial_far_end_i.recv(got, 23);
    join
    `CHK("hs byte", b, got)
    poll(`FSP_STAT_TXBUSY, 1'b0);
    $display("test handshake done");
    // block mode: two all-ones frames, start to start spans one frame
    apb(1'b1, `FSP_CTRL_ADDR, 32'h1);
    foreach (gaps[i]) begin
      apb(1'b1, `FSP_GAP_ADDR, {16'h0, gaps[i]});
      fork
        begin
          apb(1'b1, `FSP_TXDATA_ADDR, 32'h000000ff);
          apb(1'b1, `FSP_TXDATA_ADDR, 32'h000000ff);
          // holding register still full here, this byte must be dropped
          apb(1'b1, `FSP_TXDATA_ADDR, 32'h00000000);
        end
        begin
          while (serial_tx_line !== 1'b0) @(posedge pclk);
          n = 0;
          while (serial_tx_line !== 1'b1) begin @(posedge pclk); n++; end
          while (serial_tx_line !== 1'b0) begin @(posedge pclk); n++; end
        end
      join
      `CHK("frame span", frame_bits(gaps[i]) * 23, n)
      poll(`FSP_STAT_TXBUSY, 1'b0);
      apb(1'b0, `FSP_IRQ_STAT_ADDR, 32'h0);
      `CHK("tx overrun", 1'b1, rd[`FSP_IRQ_OVERRUN])
      `CHK("tx done", 1'b1, rd[`FSP_IRQ_TXDONE])
      apb(1'b1, `FSP_IRQ_STAT_ADDR, 32'h0000000f);
    end
    $display("test block gap done");
    rd = rnd();
    base = rd[15:0];
    b = rd[23:16];
    apb(1'b1, `FSP_RXBASE_ADDR, {16'h0, base});
    fork
      serial_far_end_i.send(b, 23);
      begin
        do @(posedge pclk); while (mem_wr_valid !== 1'b1);
        `CHK("mem data", b, mem_wr_data)
        `CHK("mem addr", base, mem_wr_addr)
      end
    join
    apb(1'b0, `FSP_STATUS_ADDR, 32'h0);
    `CHK("no fifo push", 1'b0, rd[0])
    $display("test block receive done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
